// ---- tre_pkg.sv ----
// constants shared by the table read / add execution block
package tre_pkg;

    // memory geometry
    localparam int TRE_PM_AW = 8;
    localparam int TRE_DF_AW = 12;
    localparam int TRE_PTR_W = 21;

    // register byte offsets within the register window
    localparam logic [7:0] TRE_OFF_INSTR = 8'h00;
    localparam logic [7:0] TRE_OFF_WORK = 8'h04;
    localparam logic [7:0] TRE_OFF_STATUS = 8'h08;
    localparam logic [7:0] TRE_OFF_BANK = 8'h0c;
    localparam logic [7:0] TRE_OFF_PTR = 8'h10;
    localparam logic [7:0] TRE_OFF_LATCH = 8'h14;

    // address windows, taken from haddr[15:12] and haddr[15:14]
    localparam logic [3:0] TRE_WIN_REG = 4'h0;
    localparam logic [3:0] TRE_WIN_PM = 4'h1;
    localparam logic [1:0] TRE_WIN_DF = 2'h1;

    // reset values
    localparam logic [7:0] TRE_RST_WORK = 8'h00;
    localparam logic [4:0] TRE_RST_STATUS = 5'h00;
    localparam logic [3:0] TRE_RST_BANK = 4'h0;
    localparam logic [20:0] TRE_RST_PTR = 21'h000000;
    localparam logic [7:0] TRE_RST_LATCH = 8'h00;
    localparam logic [15:0] TRE_RST_OPCODE = 16'h0000;

    // status flag positions
    localparam int TRE_FLG_C = 0;
    localparam int TRE_FLG_DC = 1;
    localparam int TRE_FLG_Z = 2;
    localparam int TRE_FLG_OV = 3;
    localparam int TRE_FLG_N = 4;

    // opcode fields
    localparam logic [13:0] TRE_TBL_OP = 14'h0002;
    localparam logic [5:0] TRE_ADD_OP = 6'h09;
    localparam int TRE_ADD_D_BIT = 9;
    localparam int TRE_ADD_A_BIT = 8;
    localparam logic [7:0] TRE_ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] TRE_ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] TRE_ACCESS_LO_BANK = 4'h0;

    // pointer modes
    localparam logic [1:0] TRE_MODE_KEEP = 2'h0;
    localparam logic [1:0] TRE_MODE_POST_INC = 2'h1;
    localparam logic [1:0] TRE_MODE_POST_DEC = 2'h2;
    localparam logic [1:0] TRE_MODE_PRE_INC = 2'h3;

    // phases of one instruction cycle (four clocks)
    localparam logic [1:0] TRE_Q_READ = 2'h1;
    localparam logic [1:0] TRE_Q_LAST = 2'h3;

    typedef enum logic {TRE_IDLE, TRE_EXEC} tre_state_t;

endpackage : tre_pkg

// ---- tre_mem.sv ----
// single-port memory with registered read data
`timescale 1ns/1ps
module tre_mem
    import tre_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 16
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // access port
    input wire logic [AW-1:0] addr,
    input wire logic we,
    input wire logic re,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    // array has no reset, contents are software loaded
    always_ff @(posedge hclk)
    begin
        if (we)
            mem[addr] <= wdata;
    end

    // read data held until the next read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata <= '0;
        else if (re)
            rdata <= mem[addr];
    end

endmodule : tre_mem

// ---- tre_add8.sv ----
// eight-bit adder with status flag generation
`timescale 1ns/1ps
module tre_add8
    import tre_pkg::*;
(
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // result
    output logic [7:0] sum,
    output logic [4:0] flags
);

    logic [8:0] full;
    logic [4:0] low;

    // carry from bit 7 and from bit 3, sign overflow
    always_comb
    begin
        full = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum = full[7:0];
        flags = 5'h00;
        flags[TRE_FLG_C] = full[8];
        flags[TRE_FLG_DC] = low[4];
        flags[TRE_FLG_Z] = (full[7:0] == 8'h00);
        flags[TRE_FLG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
        flags[TRE_FLG_N] = full[7];
    end

endmodule : tre_add8

// ---- tre_core.sv ----
// table read and add-to-file execution unit behind an ahb-lite slave
// Operation
// - mode field: keep, post-inc, post-dec, pre-inc
// - pointer is 21 bits, byte addressed
// - pointer bit zero picks low or high byte
// - table read: two cycles, read Q2, latch Q4
// - table read leaves all flags unchanged
// - destination bit: 1 file, 0 working register
// - bank bit: 0 access bank, 1 bank register
// - add updates N, OV, C, DC, Z
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module tre_core
    import tre_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    tre_state_t state;
    logic busy;
    logic [1:0] qph;
    logic icyc;
    logic [15:0] opcode;
    logic [7:0] work;
    logic [4:0] status;
    logic [3:0] bank;
    logic [TRE_PTR_W-1:0] ptr;
    logic [7:0] latch;

    logic dp_valid;
    logic dp_write;
    logic [15:0] dp_addr;
    logic mem_done;
    logic [31:0] rd_data;

    logic dp_reg;
    logic dp_pm;
    logic dp_df;
    logic dp_mem;
    logic mem_go;
    logic reg_wr;
    logic start;
    logic start_tbl;
    logic start_add;
    logic done;
    logic cur_tbl;
    logic [1:0] mode;
    logic [TRE_DF_AW-1:0] exec_df_addr;

    logic [TRE_PM_AW-1:0] pm_addr;
    logic pm_we;
    logic pm_re;
    logic [15:0] pm_rdata;
    logic [TRE_DF_AW-1:0] df_addr;
    logic df_we;
    logic df_re;
    logic [7:0] df_rdata;
    logic [7:0] sum;
    logic [4:0] add_flags;

    ////////////////////////////////////////////////////////////////////////
    // ahb data phase tracking

    // address phase captured only while the bus is ready
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 16'h0000;
        end
        else if (hready)
        begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[15:0];
        end
    end

    // register read data sampled at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_data <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            rd_data <= 32'h00000000;
            if (haddr[15:12] == TRE_WIN_REG)
            begin
                unique case (haddr[7:0])
                    TRE_OFF_INSTR: rd_data <= {31'h0, busy};
                    TRE_OFF_WORK: rd_data <= {24'h0, work};
                    TRE_OFF_STATUS: rd_data <= {27'h0, status};
                    TRE_OFF_BANK: rd_data <= {28'h0, bank};
                    TRE_OFF_PTR: rd_data <= {11'h0, ptr};
                    TRE_OFF_LATCH: rd_data <= {24'h0, latch};
                    default: rd_data <= 32'h00000000;
                endcase
            end
        end
    end

    // memory windows take one extra cycle for the registered read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mem_done <= 1'b0;
        else if (mem_go)
            mem_done <= 1'b1;
        else if (hreadyout)
            mem_done <= 1'b0;
    end

    // decode and stall; writes wait while an instruction runs
    always_comb
    begin
        dp_reg = dp_addr[15:12] == TRE_WIN_REG;
        dp_pm = dp_addr[15:12] == TRE_WIN_PM;
        dp_df = dp_addr[15:14] == TRE_WIN_DF;
        dp_mem = dp_pm || dp_df;
        mem_go = dp_valid && dp_mem && !mem_done && !busy;
        reg_wr = dp_valid && dp_write && !busy && dp_reg;
        hreadyout = !(dp_valid && ((dp_write && busy) ||
                      (dp_mem && !mem_done)));
        if (dp_pm)
            hrdata = {16'h0000, pm_rdata};
        else if (dp_df)
            hrdata = {24'h000000, df_rdata};
        else
            hrdata = rd_data;
    end

    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode and sequencing

    // unknown opcodes are accepted by the bus and never executed
    always_comb
    begin
        start = reg_wr && dp_addr[7:0] == TRE_OFF_INSTR &&
                (hwdata[15:2] == TRE_TBL_OP || hwdata[15:10] == TRE_ADD_OP);
        start_tbl = start && hwdata[15:2] == TRE_TBL_OP;
        start_add = start && !start_tbl;
        busy = state == TRE_EXEC;
        cur_tbl = opcode[15:2] == TRE_TBL_OP;
        mode = opcode[1:0];
        done = busy && qph == TRE_Q_LAST && (icyc || !cur_tbl);
    end

    // access bank splits low ram and the high special bank
    always_comb
    begin
        if (opcode[TRE_ADD_A_BIT])
            exec_df_addr = {bank, opcode[7:0]};
        else if (opcode[7:0] < TRE_ACCESS_SPLIT)
            exec_df_addr = {TRE_ACCESS_LO_BANK, opcode[7:0]};
        else
            exec_df_addr = {TRE_ACCESS_HI_BANK, opcode[7:0]};
    end

    // four clocks per instruction cycle, two cycles for a table read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= TRE_IDLE;
            qph <= 2'h0;
            icyc <= 1'b0;
            opcode <= TRE_RST_OPCODE;
        end
        else if (start)
        begin
            state <= TRE_EXEC;
            qph <= 2'h0;
            icyc <= 1'b0;
            opcode <= hwdata[15:0];
        end
        else if (busy)
        begin
            qph <= qph + 2'h1;
            if (done)
                state <= TRE_IDLE;
            else if (qph == TRE_Q_LAST)
                icyc <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // architectural registers

    // pre-increment lands before the second-cycle read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ptr <= TRE_RST_PTR;
        else if (reg_wr && dp_addr[7:0] == TRE_OFF_PTR)
            ptr <= hwdata[TRE_PTR_W-1:0];
        else if (busy && cur_tbl && qph == TRE_Q_LAST)
        begin
            if (!icyc && mode == TRE_MODE_PRE_INC)
                ptr <= ptr + 21'h000001;
            else if (icyc && mode == TRE_MODE_POST_INC)
                ptr <= ptr + 21'h000001;
            else if (icyc && mode == TRE_MODE_POST_DEC)
                ptr <= ptr - 21'h000001;
        end
    end

    // latch written in the last phase of the second cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latch <= TRE_RST_LATCH;
        else if (busy && cur_tbl && icyc && qph == TRE_Q_LAST)
            latch <= ptr[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    end

    // working register: software write or add result
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            work <= TRE_RST_WORK;
        else if (reg_wr && dp_addr[7:0] == TRE_OFF_WORK)
            work <= hwdata[7:0];
        else if (done && !cur_tbl && !opcode[TRE_ADD_D_BIT])
            work <= sum;
    end

    // flags change on add or software write, table reads leave them alone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status <= TRE_RST_STATUS;
        else if (reg_wr && dp_addr[7:0] == TRE_OFF_STATUS)
            status <= hwdata[4:0];
        else if (done && !cur_tbl)
            status <= add_flags;
    end

    // bank register, software owned
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bank <= TRE_RST_BANK;
        else if (reg_wr && dp_addr[7:0] == TRE_OFF_BANK)
            bank <= hwdata[3:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // memories and adder

    // execution owns both ports while busy, the bus otherwise
    always_comb
    begin
        if (busy)
        begin
            pm_addr = ptr[TRE_PM_AW:1];
            pm_re = cur_tbl && icyc && qph == TRE_Q_READ;
            pm_we = 1'b0;
            df_addr = exec_df_addr;
            df_re = !cur_tbl && qph == TRE_Q_READ;
            df_we = done && !cur_tbl && opcode[TRE_ADD_D_BIT];
        end
        else
        begin
            pm_addr = dp_addr[TRE_PM_AW+1:2];
            pm_re = mem_go && dp_pm && !dp_write;
            pm_we = mem_go && dp_pm && dp_write;
            df_addr = dp_addr[TRE_DF_AW+1:2];
            df_re = mem_go && dp_df && !dp_write;
            df_we = mem_go && dp_df && dp_write;
        end
    end

    tre_mem #(.AW(TRE_PM_AW), .DW(16)) u_pmem (
        .hclk(hclk),
        .hresetn(hresetn),
        .addr(pm_addr),
        .we(pm_we),
        .re(pm_re),
        .wdata(hwdata[15:0]),
        .rdata(pm_rdata)
    );

    // file write data is the sum while busy
    tre_mem #(.AW(TRE_DF_AW), .DW(8)) u_dfile (
        .hclk(hclk),
        .hresetn(hresetn),
        .addr(df_addr),
        .we(df_we),
        .re(df_re),
        .wdata(busy ? sum : hwdata[7:0]),
        .rdata(df_rdata)
    );

    tre_add8 u_add (
        .a(work),
        .b(df_rdata),
        .sum(sum),
        .flags(add_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [TRE_PTR_W-1:0] ptr0;
    logic [TRE_PTR_W-1:0] ptr0_inc;

    // pointer at the start of the instruction
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ptr0 <= TRE_RST_PTR;
        else if (start)
            ptr0 <= ptr;
    end

    assign ptr0_inc = ptr0 + 21'h000001;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_tbl_keep;
        done && cur_tbl && mode == TRE_MODE_KEEP |=> ptr == ptr0;
    endproperty
    a_tbl_keep: assert property (p_tbl_keep)
        else $error("pointer moved in keep mode");

    property p_tbl_post_inc;
        done && cur_tbl && mode == TRE_MODE_POST_INC |=> ptr == ptr0_inc;
    endproperty
    a_tbl_post_inc: assert property (p_tbl_post_inc)
        else $error("post increment wrong");

    property p_tbl_post_dec;
        done && cur_tbl && mode == TRE_MODE_POST_DEC |=>
            ptr == ptr0 - 21'h000001;
    endproperty
    a_tbl_post_dec: assert property (p_tbl_post_dec)
        else $error("post decrement wrong");

    property p_tbl_pre_inc;
        pm_re && busy && mode == TRE_MODE_PRE_INC |->
            pm_addr == ptr0_inc[TRE_PM_AW:1];
    endproperty
    a_tbl_pre_inc: assert property (p_tbl_pre_inc)
        else $error("pre increment not before read");

    property p_tbl_byte;
        done && cur_tbl |=> latch == (ptr0[0] ^ (mode == TRE_MODE_PRE_INC) ?
            $past(pm_rdata[15:8]) : $past(pm_rdata[7:0]));
    endproperty
    a_tbl_byte: assert property (p_tbl_byte)
        else $error("wrong byte latched");

    property p_tbl_timing;
        start_tbl |=> (busy && !pm_re) [*5] ##1 pm_re ##1 busy [*2] ##1 !busy;
    endproperty
    a_tbl_timing: assert property (p_tbl_timing)
        else $error("table read timing wrong");

    property p_tbl_flags;
        done && cur_tbl |=> $stable(status);
    endproperty
    a_tbl_flags: assert property (p_tbl_flags)
        else $error("table read changed flags");

    property p_add_dest;
        done && !cur_tbl |-> (df_we == opcode[TRE_ADD_D_BIT]) ##1
            (work == ($past(opcode[TRE_ADD_D_BIT]) ?
                      $past(work) : $past(sum)));
    endproperty
    a_add_dest: assert property (p_add_dest)
        else $error("add destination wrong");

    property p_add_bank;
        busy && df_re && opcode[TRE_ADD_A_BIT] |-> df_addr[11:8] == bank;
    endproperty
    a_add_bank: assert property (p_add_bank)
        else $error("bank addressing wrong");

    property p_add_flags;
        start_add |=> busy [*4] ##0 (status == $past(status, 4)) ##1
            (!busy && status[TRE_FLG_Z] == ($past(sum) == 8'h00) &&
             status[TRE_FLG_N] == $past(sum[7]));
    endproperty
    a_add_flags: assert property (p_add_flags)
        else $error("add flags wrong");

endmodule : tre_core

// ---- tre_ahb_master.sv ----
// ahb-lite single-transfer master standing in for software
`timescale 1ns/1ps
module tre_ahb_master
(
    // clock
    input wire logic hclk,
    // request side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata,
    // answer side
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    logic timed_out;

    ////////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        timed_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
            timed_out = 1'b1;
    endtask : wait_ready

    // one word transfer; the leading edge keeps drives of two calls apart
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer

endmodule : tre_ahb_master

// ---- tb_table_read_and_add_exec.sv ----
// self-checking bench for the table read / add execution block
`timescale 1ns/1ps
module tb_table_read_and_add_exec
    import tre_pkg::*;
;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic [7:0] latch_exp;
    int n_mismatch;
    int num_checks;

    ////////////////////////////////////////////////////////////////////////
    // design and bus master; single slave, so hready is hreadyout
    tre_core tre_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    tre_ahb_master tre_ahb_master_i (.hclk(hclk), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));

    // 200 mhz clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // a stuck bus ends the run at once
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        tre_ahb_master_i.xfer(wr, a, wd, rv);
        if (tre_ahb_master_i.timed_out)
        begin
            n_mismatch++;
            $display("ERROR bus wait ran out");
            end_sim();
        end
    endtask : bus

    // writes stall while busy, so poll the busy bit with a bound
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            bus(1'b0, 32'(TRE_OFF_INSTR), 32'h0);
            n++;
        end
        while (rv[0] !== 1'b0 && n < 40);
        if (rv[0] !== 1'b0)
        begin
            n_mismatch++;
            $display("ERROR busy never cleared");
            end_sim();
        end
    endtask : wait_idle

    function automatic logic [15:0] pmw(input logic [7:0] n);
        return {8'ha0 ^ n, 8'h5c ^ n};
    endfunction : pmw

    ////////////////////////////////////////////////////////////////////////
    // one table read with flags preset, checked before and after it lands
    task automatic tbl(input logic [20:0] p, input logic [1:0] mode);
        logic [20:0] f;
        logic [20:0] np;
        logic [15:0] w;
        logic [7:0] b;
        f = (mode == TRE_MODE_PRE_INC) ? p + 21'h1 : p;
        w = pmw(f[8:1]);
        b = f[0] ? w[15:8] : w[7:0];
        np = (mode == TRE_MODE_KEEP) ? p :
             (mode == TRE_MODE_POST_DEC) ? p - 21'h1 : p + 21'h1;
        bus(1'b1, 32'(TRE_OFF_PTR), {11'h0, p});
        bus(1'b1, 32'(TRE_OFF_STATUS), 32'h1f);
        bus(1'b1, 32'(TRE_OFF_INSTR), {16'h0, TRE_TBL_OP, mode});
        bus(1'b0, 32'(TRE_OFF_LATCH), 32'h0);
        check("latch early", rv, {24'h0, latch_exp});
        bus(1'b0, 32'(TRE_OFF_INSTR), 32'h0);
        check("busy", rv, 32'h1);
        wait_idle();
        bus(1'b0, 32'(TRE_OFF_LATCH), 32'h0);
        check("latch", rv, {24'h0, b});
        bus(1'b0, 32'(TRE_OFF_PTR), 32'h0);
        check("pointer", rv, {11'h0, np});
        bus(1'b0, 32'(TRE_OFF_STATUS), 32'h0);
        check("flags kept", rv, 32'h1f);
        latch_exp = b;
    endtask : tbl

    // one add; a decoy sits at the address the other bank mode would use
    task automatic add(input logic d, input logic a, input logic [7:0] f,
                       input logic [7:0] w, input logic [7:0] fv,
                       input logic [7:0] dv);
        logic [11:0] acc;
        logic [11:0] sel;
        logic [11:0] oth;
        logic [8:0] s;
        logic [4:0] fl;
        acc = f[7] ? {4'hf, f} : {4'h0, f};
        sel = a ? {4'h3, f} : acc;
        oth = a ? acc : {4'h3, f};
        s = {1'b0, w} + {1'b0, fv};
        fl[TRE_FLG_C] = s[8];
        fl[TRE_FLG_DC] = ({1'b0, w[3:0]} + {1'b0, fv[3:0]}) > 5'hf;
        fl[TRE_FLG_Z] = (s[7:0] == 8'h00);
        fl[TRE_FLG_OV] = (w[7] == fv[7]) && (s[7] != w[7]);
        fl[TRE_FLG_N] = s[7];
        bus(1'b1, 32'(TRE_OFF_BANK), 32'h3);
        bus(1'b1, 32'h4000 + {18'h0, sel, 2'h0}, {24'h0, fv});
        bus(1'b1, 32'h4000 + {18'h0, oth, 2'h0}, {24'h0, dv});
        bus(1'b1, 32'(TRE_OFF_WORK), {24'h0, w});
        bus(1'b1, 32'(TRE_OFF_STATUS), 32'h0);
        bus(1'b1, 32'(TRE_OFF_INSTR), {16'h0, TRE_ADD_OP, d, a, f});
        wait_idle();
        bus(1'b0, 32'(TRE_OFF_STATUS), 32'h0);
        check("flags", rv, {27'h0, fl});
        bus(1'b0, 32'(TRE_OFF_WORK), 32'h0);
        check("work", rv, {24'h0, d ? w : s[7:0]});
        bus(1'b0, 32'h4000 + {18'h0, sel, 2'h0}, 32'h0);
        check("file", rv, {24'h0, d ? s[7:0] : fv});
        bus(1'b0, 32'h4000 + {18'h0, oth, 2'h0}, 32'h0);
        check("decoy", rv, {24'h0, dv});
    endtask : add

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        latch_exp = 8'h00;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, read-only latch, unmapped hole, pointer width
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, 32'(4 * i), 32'h0);
            check("reset value", rv, 32'h0);
        end
        bus(1'b1, 32'(TRE_OFF_LATCH), 32'hffffffff);
        bus(1'b1, 32'h18, 32'hffffffff);
        bus(1'b0, 32'(TRE_OFF_LATCH), 32'h0);
        check("latch read only", rv, 32'h0);
        bus(1'b0, 32'h18, 32'h0);
        check("unmapped", rv, 32'h0);
        bus(1'b1, 32'(TRE_OFF_PTR), 32'hffffffff);
        bus(1'b0, 32'(TRE_OFF_PTR), 32'h0);
        check("pointer width", rv, 32'h1fffff);
        check("response okay", {31'h0, hresp}, 32'h0);
        $display("test registers done");
        // program words 0..7 and 255, then every pointer mode
        for (int n = 0; n < 9; n++)
            bus(1'b1, 32'h1000 + 32'(4 * ((n == 8) ? 255 : n)),
                {16'h0, pmw(8'((n == 8) ? 255 : n))});
        bus(1'b0, 32'h1004, 32'h0);
        check("program word", rv, {16'h0, pmw(8'h01)});
        tbl(21'h000004, TRE_MODE_KEEP);
        tbl(21'h000005, TRE_MODE_POST_INC);
        tbl(21'h000006, TRE_MODE_POST_DEC);
        tbl(21'h000007, TRE_MODE_PRE_INC);
        tbl(21'h1fffff, TRE_MODE_POST_INC);
        tbl(21'h000000, TRE_MODE_POST_DEC);
        $display("test table read done");
        // every destination and bank mode, with flag corners
        add(1'b0, 1'b0, 8'h10, 8'h17, 8'hc2, 8'h55);
        add(1'b1, 1'b0, 8'h85, 8'h80, 8'h80, 8'haa);
        add(1'b0, 1'b1, 8'h10, 8'h0f, 8'h01, 8'h66);
        add(1'b1, 1'b1, 8'ha0, 8'h7f, 8'h01, 8'h11);
        $display("test add done");
        end_sim();
    end

endmodule : tb_table_read_and_add_exec
